// *** rtl/toic_params.svh ***
// Constants of the tape order and interlock control: offsets, fields, counts.
// Assumes nothing; definitions only.
`ifndef TOIC_PARAMS_SVH
`define TOIC_PARAMS_SVH
`define TOIC_OFF_ORDER 4'h0
`define TOIC_OFF_STAT 4'h4
`define TOIC_OFF_CLR 4'h8
`define TOIC_OFF_MAP 4'hc
`define TOIC_F_OP 3:0
`define TOIC_F_UNIT 7:4
`define TOIC_F_ADDR 17:8
`define TOIC_F_MAP_A 3:0
`define TOIC_F_MAP_B 7:4
`define TOIC_F_MAP_EN 8
`define TOIC_B_WF 0
`define TOIC_B_RF 1
`define TOIC_MAP_RST 9'h000
`define TOIC_WAIT_RST 1'b1
`define TOIC_NUNITS 10
`define TOIC_NLAMPS 7
`define TOIC_WORDS 60
`define TOIC_NDIG 12
`define TOIC_DIG_W 6
`define TOIC_WORD_W 72
`define TOIC_LAST_WORD 6'h3b
`define TOIC_LAST_DIGIT 4'hb
`define TOIC_UNIT_MINUS 4'ha
`endif

// *** rtl/toic_pkg.sv ***
// Types shared by the tape order and interlock control.
// Assumes toic_params.svh on the include path.
`default_nettype none
`include "toic_params.svh"
package toic_pkg;
	typedef logic [`TOIC_WORD_W-1:0] toic_word_t;
	typedef enum logic [3:0] {TOIC_OP_NONE = 4'h0, TOIC_OP_RDF = 4'h1, TOIC_OP_RDB = 4'h2,
		TOIC_OP_XFR_F = 4'h3, TOIC_OP_XFR_B = 4'h4, TOIC_OP_WRH = 4'h5, TOIC_OP_REW = 4'h6,
		TOIC_OP_WRL = 4'h7, TOIC_OP_REWL = 4'h8} toic_op_t;
	typedef enum logic [2:0] {TOIC_U_IDLE, TOIC_U_RDF, TOIC_U_RDB, TOIC_U_WR, TOIC_U_REW,
		TOIC_U_REWL} toic_uop_t;
	typedef enum logic [2:0] {TOIC_ST_IDLE, TOIC_ST_ACK, TOIC_ST_CHECK, TOIC_ST_M2O,
		TOIC_ST_I2M} toic_st_t;
	typedef struct packed {
		toic_word_t [`TOIC_WORDS-1:0] w;
	} toic_buf_t;
	typedef struct packed {
		toic_st_t st;
		logic wait_;
		logic [31:0] rdata;
		toic_op_t op;
		logic [3:0] digit;
		logic hasu;
		logic [3:0] pu;
		logic [9:0] addr;
		logic [5:0] cnt;
		logic idone;
		logic [5:0] mridx;
		logic pend;
		logic [5:0] pidx;
		logic [8:0] map;
		logic wr_busy;
		logic rd_busy;
		logic wr_fail;
		logic rd_fail;
		logic [`TOIC_NUNITS-1:0] lock;
		toic_uop_t [`TOIC_NUNITS-1:0] uop;
		logic [3:0] wr_u;
		logic [3:0] rd_u;
		logic wr_low;
		logic [5:0] ww;
		logic [5:0] rw;
		logic [3:0] wd;
		logic [3:0] rd;
		logic wvalid;
		logic [`TOIC_DIG_W-1:0] wdig;
		logic [9:0] mem_addr;
		logic mem_re;
		logic mem_we;
		toic_word_t mem_wdata;
		logic [`TOIC_NUNITS-1:0] fwd;
		logic [`TOIC_NUNITS-1:0] bwd;
		logic [`TOIC_NUNITS-1:0] wrt;
		logic [`TOIC_NUNITS-1:0] rew;
		logic [`TOIC_NUNITS*`TOIC_NLAMPS-1:0] lamps;
	} toic_main_t;
endpackage
`default_nettype wire

// *** rtl/toic_buf_if.sv ***
// Port group between the controller and one 60-word block buffer.
// Assumes the controller drives every request signal each cycle.
`timescale 1ns/1ns
`default_nettype none
interface toic_buf_if;
	logic clr;
	logic we;
	logic [5:0] widx;
	logic [11:0] mask;
	toic_pkg::toic_word_t wdata;
	logic [5:0] ridx;
	toic_pkg::toic_word_t rdata;
	modport ctl (output clr, output we, output widx, output mask, output wdata, output ridx,
		input rdata);
	modport store (input clr, input we, input widx, input mask, input wdata, input ridx,
		output rdata);
endinterface
`default_nettype wire

// *** rtl/toic_blkbuf.sv ***
// Block buffer of 60 words with digit-masked write, one-cycle clear, async read.
// Assumes ridx stays below 60; a clear overrides a write in the same cycle.
`timescale 1ns/1ns
`default_nettype none
`include "toic_params.svh"
module toic_blkbuf (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	toic_buf_if.store b
);
	toic_pkg::toic_buf_t s;
	toic_pkg::toic_buf_t s_nxt;
	toic_pkg::toic_word_t [`TOIC_WORDS-1:0] word_nxt;
	toic_pkg::toic_word_t mexp;
	genvar g;
	generate
		for (g = 0; g < `TOIC_WORDS; g++)
		begin : g_word
			if (g < `TOIC_NDIG)
			begin : g_dig
				assign mexp[g*`TOIC_DIG_W +: `TOIC_DIG_W] = {`TOIC_DIG_W{b.mask[g]}};
			end
			assign word_nxt[g] = b.clr ? '0 :
				(b.we && b.widx == 6'(g)) ? ((b.wdata & mexp) | (s.w[g] & ~mexp)) : s.w[g];
		end
	endgenerate
	always_comb
	begin
		s_nxt = s;
		s_nxt.w = word_nxt;
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			s <= '0;
		else if (ce)
			s <= s_nxt;
	end
	assign b.rdata = s.w[b.ridx];
	a_clr_zero: assert property (@(posedge clk) disable iff (!nrst) // [RQ9]
		(ce && b.clr) |=> (s.w[0] == '0 && s.w[`TOIC_WORDS-1] == '0))
		else $error("buffer not zero after clear");
endmodule // toic_blkbuf
`default_nettype wire

// *** rtl/toic_ctl.sv ***
// Tape order and interlock control: Avalon-MM slave, order decode, interlocks,
// memory to buffer moves and the digit-serial tape side for up to ten units.
// Assumes a synchronous main memory (data one cycle after mem_re) and tape
// units that report digits, holes, errors and rewind completion synchronously.
// Operation
// [RQ1] Write checks prior write, failure, unit busy
// [RQ2] Write also blocked by write-protect ring
// [RQ3] Blocked write holds computer until all clear
// [RQ4] Read checks prior read, failure, unit busy
// [RQ5] Blocked read stalls computer until clear
// [RQ6] Write proceeds while other unit reads
// [RQ7] Unit digit 1-9 or minus for tenth
// [RQ8] Buffers unreachable by software, transfer only
// [RQ9] Output buffer zeroed after every write
// [RQ10] Input buffer zeroed after memory transfer
// [RQ11] Opcode 1 reads block forward
// [RQ12] Opcode 2 reads block backward
// [RQ13] Order 30 copies buffer to m..m+59
// [RQ14] Order 40 equals order 30
// [RQ15] Order 3n transfers then reads forward
// [RQ16] Order 4n transfers then reads backward
// [RQ17] Order 5n fills buffer, writes high density
// [RQ18] Order 7n writes at low density
// [RQ19] Reads accept either density
// [RQ20] Order 6n rewinds to first block
// [RQ21] Order 8n rewinds and locks unit
// [RQ22] Punched region suspends transfer until passed
// [RQ23] Lamps show the operation under way
// [RQ24] Lamps stay lit after unit error
// [RQ25] Two logical unit numbers may swap
// [RQ26] Computer released once transfer starts
// [RQ27] Sign digit first; stop after last digit
// [RQ28] Backward read fills buffer in order
// [RQ29] Busy and failure state kept registered
// [RQ30] Stall has no timeout, rechecked each cycle
`timescale 1ns/1ns
`default_nettype none
`include "toic_params.svh"
module toic_ctl (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [9:0] mem_addr,
	output logic mem_re,
	output logic mem_we,
	output logic [`TOIC_WORD_W-1:0] mem_wdata,
	input wire logic [`TOIC_WORD_W-1:0] mem_rdata,
	input wire logic [`TOIC_NUNITS-1:0] tape_ready,
	input wire logic [`TOIC_NUNITS-1:0] tape_ring,
	input wire logic [`TOIC_NUNITS-1:0] tape_removed,
	input wire logic [`TOIC_NUNITS-1:0] tape_rew_done,
	input wire logic [`TOIC_NUNITS-1:0] tape_hole,
	input wire logic [`TOIC_NUNITS-1:0] tape_error,
	input wire logic rd_digit_valid,
	input wire logic [`TOIC_DIG_W-1:0] rd_digit,
	input wire logic wr_digit_ready,
	output logic wr_digit_valid,
	output logic [`TOIC_DIG_W-1:0] wr_digit,
	output logic wr_low_density,
	output logic [`TOIC_NUNITS-1:0] tape_fwd,
	output logic [`TOIC_NUNITS-1:0] tape_bwd,
	output logic [`TOIC_NUNITS-1:0] tape_write,
	output logic [`TOIC_NUNITS-1:0] tape_rewind,
	output logic [`TOIC_NUNITS*`TOIC_NLAMPS-1:0] lamps
);
	toic_pkg::toic_main_t s;
	toic_pkg::toic_main_t s_nxt;
	logic [`TOIC_NUNITS-1:0] ub;
	logic [`TOIC_NUNITS*`TOIC_NLAMPS-1:0] lamp_nxt;
	logic is_rd;
	logic is_wr;
	logic blk_rd;
	logic blk_wr;
	toic_buf_if ob ();
	toic_buf_if ib ();

	// Buffers have no software path: only the movers below touch them
	toic_blkbuf u_obuf (.clk(clk), .nrst(nrst), .ce(ce), .b(ob.store)); // [RQ8]
	toic_blkbuf u_ibuf (.clk(clk), .nrst(nrst), .ce(ce), .b(ib.store));

	// Swap two logical unit digits
	function automatic logic [3:0] toic_map(input logic [3:0] d, input logic [8:0] m);
		logic [3:0] r;
		r = d;
		if (m[`TOIC_F_MAP_EN] && d == m[`TOIC_F_MAP_A])
			r = m[`TOIC_F_MAP_B];
		else if (m[`TOIC_F_MAP_EN] && d == m[`TOIC_F_MAP_B])
			r = m[`TOIC_F_MAP_A];
		return r;
	endfunction

	// Density is not chosen for reads; the unit recovers either one
	function automatic toic_pkg::toic_main_t rd_go(input toic_pkg::toic_main_t x,
		input logic bw);
		toic_pkg::toic_main_t y;
		y = x;
		y.rd_busy = 1'b1;
		y.rd_u = x.pu;
		y.rw = bw ? `TOIC_LAST_WORD : 6'h00; // [RQ28]
		y.rd = bw ? `TOIC_LAST_DIGIT : 4'h0;
		if (bw)
			y.bwd[x.pu] = 1'b1; // [RQ12] [RQ19]
		else
			y.fwd[x.pu] = 1'b1; // [RQ11]
		y.uop[x.pu] = bw ? toic_pkg::TOIC_U_RDB : toic_pkg::TOIC_U_RDF;
		return y;
	endfunction

	genvar g;
	generate
		for (g = 0; g < `TOIC_NUNITS; g++)
		begin : g_unit
			logic rf;
			logic rb;
			logic wr;
			logic rw;
			assign rf = s.uop[g] == toic_pkg::TOIC_U_RDF;
			assign rb = s.uop[g] == toic_pkg::TOIC_U_RDB;
			assign wr = s.uop[g] == toic_pkg::TOIC_U_WR;
			assign rw = s.uop[g] == toic_pkg::TOIC_U_REW || s.uop[g] == toic_pkg::TOIC_U_REWL;
			assign ub[g] = s.uop[g] != toic_pkg::TOIC_U_IDLE; // [RQ29]
			// Lamps 7..1; a failed operation keeps its uop and so its lamps
			assign lamp_nxt[g*`TOIC_NLAMPS +: `TOIC_NLAMPS] =
				{wr, rf | rb, rb, rf | wr, s.lock[g], rw, tape_ready[g]}; // [RQ23] [RQ24]
		end
	endgenerate

	assign is_rd = s.op == toic_pkg::TOIC_OP_RDF || s.op == toic_pkg::TOIC_OP_RDB;
	assign is_wr = s.op == toic_pkg::TOIC_OP_WRH || s.op == toic_pkg::TOIC_OP_WRL;
	// Read and write busy are separate, so a read elsewhere never blocks a write
	assign blk_rd = s.rd_busy | s.rd_fail | ub[s.pu] | s.lock[s.pu]; // [RQ4] [RQ21] [RQ6]
	assign blk_wr = s.wr_busy | s.wr_fail | ub[s.pu] | s.lock[s.pu] | tape_ring[s.pu]; // [RQ1] [RQ2]

	always_comb
	begin
		logic fin;
		logic [3:0] md;
		fin = 1'b0;
		md = 4'h0;
		s_nxt = s;
		s_nxt.mem_re = 1'b0;
		s_nxt.mem_we = 1'b0;
		s_nxt.pend = s.mem_re;
		s_nxt.pidx = s.mridx;
		ob.clr = 1'b0;
		ob.we = 1'b0;
		ob.widx = s.pidx;
		ob.mask = '1;
		ob.wdata = mem_rdata;
		ob.ridx = s.ww;
		ib.clr = 1'b0;
		ib.we = 1'b0;
		ib.widx = s.rw;
		ib.mask = 12'h800 >> s.rd;
		ib.wdata = {`TOIC_NDIG{rd_digit}};
		ib.ridx = s.cnt;
		for (int u = 0; u < `TOIC_NUNITS; u++)
		begin
			if (s.rew[u] && tape_rew_done[u])
			begin
				s_nxt.rew[u] = 1'b0; // [RQ20]
				s_nxt.uop[u] = toic_pkg::TOIC_U_IDLE;
			end
			if (tape_removed[u])
				s_nxt.lock[u] = 1'b0; // [RQ21]
		end
		// Digits inside a punched region are dropped and the position held
		if (s.rd_busy && rd_digit_valid && !tape_hole[s.rd_u]) // [RQ22]
		begin
			ib.we = 1'b1;
			if (s.rw == (s.fwd[s.rd_u] ? `TOIC_LAST_WORD : 6'h00) &&
				s.rd == (s.fwd[s.rd_u] ? `TOIC_LAST_DIGIT : 4'h0))
			begin
				s_nxt.rd_busy = 1'b0;
				s_nxt.fwd[s.rd_u] = 1'b0;
				s_nxt.bwd[s.rd_u] = 1'b0;
				s_nxt.uop[s.rd_u] = toic_pkg::TOIC_U_IDLE;
			end
			else if (s.fwd[s.rd_u])
			begin
				s_nxt.rd = (s.rd == `TOIC_LAST_DIGIT) ? 4'h0 : s.rd + 4'h1;
				s_nxt.rw = (s.rd == `TOIC_LAST_DIGIT) ? s.rw + 6'h01 : s.rw;
			end
			else
			begin
				s_nxt.rd = (s.rd == 4'h0) ? `TOIC_LAST_DIGIT : s.rd - 4'h1; // [RQ28]
				s_nxt.rw = (s.rd == 4'h0) ? s.rw - 6'h01 : s.rw;
			end
		end
		if (s.wr_busy)
		begin
			if (s.wvalid && wr_digit_ready)
			begin
				s_nxt.wvalid = 1'b0;
				if (s.ww == `TOIC_LAST_WORD && s.wd == `TOIC_LAST_DIGIT)
				begin
					s_nxt.wr_busy = 1'b0;
					s_nxt.wrt[s.wr_u] = 1'b0; // [RQ27]
					s_nxt.uop[s.wr_u] = toic_pkg::TOIC_U_IDLE;
					ob.clr = 1'b1; // [RQ9]
				end
				else if (s.wd == `TOIC_LAST_DIGIT)
				begin
					s_nxt.wd = 4'h0;
					s_nxt.ww = s.ww + 6'h01;
				end
				else
					s_nxt.wd = s.wd + 4'h1;
			end
			else if (tape_hole[s.wr_u])
				s_nxt.wvalid = 1'b0; // [RQ22]
			else if (!s.wvalid)
			begin
				s_nxt.wvalid = 1'b1;
				// Digit 0 is the sign, sent first from the top of the word
				s_nxt.wdig = ob.rdata[7'd66 - 7'(s.wd) * 7'd6 +: `TOIC_DIG_W]; // [RQ27]
			end
		end
		case (s.st)
			toic_pkg::TOIC_ST_IDLE:
			begin
				if (avs_write && avs_address == `TOIC_OFF_ORDER)
				begin
					md = toic_map(avs_writedata[`TOIC_F_UNIT], s.map); // [RQ25]
					s_nxt.op = toic_pkg::toic_op_t'(avs_writedata[`TOIC_F_OP]);
					s_nxt.digit = avs_writedata[`TOIC_F_UNIT];
					s_nxt.hasu = md != 4'h0 && md <= `TOIC_UNIT_MINUS; // [RQ7]
					s_nxt.pu = md - 4'h1;
					s_nxt.addr = avs_writedata[`TOIC_F_ADDR];
					s_nxt.st = toic_pkg::TOIC_ST_CHECK;
				end
				else if (avs_write || avs_read)
				begin
					fin = 1'b1;
					s_nxt.rdata = 32'h0000_0000;
					case (avs_address)
						`TOIC_OFF_ORDER:
							s_nxt.rdata = {14'h0000, s.addr, s.digit, s.op};
						`TOIC_OFF_STAT:
							s_nxt.rdata = {8'h00, ub, s.lock, s.rd_fail, s.wr_fail, s.rd_busy,
								s.wr_busy};
						`TOIC_OFF_MAP:
						begin
							s_nxt.rdata = {23'h000000, s.map};
							if (avs_write)
								s_nxt.map = avs_writedata[8:0];
						end
						`TOIC_OFF_CLR:
						begin
							if (avs_write && avs_writedata[`TOIC_B_WF])
								s_nxt.wr_fail = 1'b0;
							if (avs_write && avs_writedata[`TOIC_B_RF])
								s_nxt.rd_fail = 1'b0;
							for (int u = 0; u < `TOIC_NUNITS; u++)
							begin
								if (avs_write && avs_writedata[`TOIC_B_WF] && !s.wrt[u] &&
									s.uop[u] == toic_pkg::TOIC_U_WR)
									s_nxt.uop[u] = toic_pkg::TOIC_U_IDLE;
								if (avs_write && avs_writedata[`TOIC_B_RF] && !s.fwd[u] &&
									!s.bwd[u] && (s.uop[u] == toic_pkg::TOIC_U_RDF ||
									s.uop[u] == toic_pkg::TOIC_U_RDB))
									s_nxt.uop[u] = toic_pkg::TOIC_U_IDLE;
							end
						end
						default:
							s_nxt.rdata = 32'h0000_0000;
					endcase
				end
			end
			toic_pkg::TOIC_ST_ACK:
			begin
				s_nxt.wait_ = 1'b1;
				s_nxt.st = toic_pkg::TOIC_ST_IDLE;
			end
			// Re-evaluated every cycle; no timeout ends a stall
			toic_pkg::TOIC_ST_CHECK: // [RQ30]
			begin
				case (s.op)
					toic_pkg::TOIC_OP_RDF, toic_pkg::TOIC_OP_RDB:
					begin
						if (!s.hasu)
							fin = 1'b1;
						else if (!blk_rd) // [RQ5]
						begin
							s_nxt = rd_go(s_nxt, s.op == toic_pkg::TOIC_OP_RDB);
							fin = 1'b1;
						end
					end
					toic_pkg::TOIC_OP_XFR_F, toic_pkg::TOIC_OP_XFR_B:
					begin
						// Also waits for a read in flight, so no half block moves
						if (!s.rd_busy && !(s.hasu && blk_rd)) // [RQ14]
						begin
							s_nxt.st = toic_pkg::TOIC_ST_I2M;
							s_nxt.cnt = 6'h00;
						end
					end
					toic_pkg::TOIC_OP_WRH, toic_pkg::TOIC_OP_WRL:
					begin
						if (!s.hasu)
							fin = 1'b1;
						else if (!blk_wr) // [RQ3]
						begin
							s_nxt.st = toic_pkg::TOIC_ST_M2O;
							s_nxt.cnt = 6'h00;
							s_nxt.idone = 1'b0;
						end
					end
					toic_pkg::TOIC_OP_REW, toic_pkg::TOIC_OP_REWL:
					begin
						if (!s.hasu)
							fin = 1'b1;
						else if (!ub[s.pu])
						begin
							s_nxt.rew[s.pu] = 1'b1; // [RQ20]
							s_nxt.uop[s.pu] = (s.op == toic_pkg::TOIC_OP_REWL) ?
								toic_pkg::TOIC_U_REWL : toic_pkg::TOIC_U_REW;
							if (s.op == toic_pkg::TOIC_OP_REWL)
								s_nxt.lock[s.pu] = 1'b1; // [RQ21]
							fin = 1'b1;
						end
					end
					default:
						fin = 1'b1;
				endcase
			end
			toic_pkg::TOIC_ST_M2O:
			begin
				if (!s.idone)
				begin
					s_nxt.mem_re = 1'b1; // [RQ17]
					s_nxt.mem_addr = s.addr + {4'h0, s.cnt};
					s_nxt.mridx = s.cnt;
					s_nxt.cnt = s.cnt + 6'h01;
					s_nxt.idone = s.cnt == `TOIC_LAST_WORD;
				end
				ob.we = s.pend;
				if (s.pend && s.pidx == `TOIC_LAST_WORD)
				begin
					s_nxt.wr_busy = 1'b1;
					s_nxt.wr_u = s.pu;
					s_nxt.wr_low = s.op == toic_pkg::TOIC_OP_WRL; // [RQ18]
					s_nxt.wrt[s.pu] = 1'b1;
					s_nxt.ww = 6'h00;
					s_nxt.wd = 4'h0;
					s_nxt.uop[s.pu] = toic_pkg::TOIC_U_WR;
					fin = 1'b1;
				end
			end
			toic_pkg::TOIC_ST_I2M:
			begin
				s_nxt.mem_we = 1'b1; // [RQ13]
				s_nxt.mem_addr = s.addr + {4'h0, s.cnt};
				s_nxt.mem_wdata = ib.rdata;
				s_nxt.cnt = s.cnt + 6'h01;
				if (s.cnt == `TOIC_LAST_WORD)
				begin
					ib.clr = 1'b1; // [RQ10]
					if (s.hasu)
						s_nxt = rd_go(s_nxt, s.op == toic_pkg::TOIC_OP_XFR_B); // [RQ15] [RQ16]
					fin = 1'b1;
				end
			end
			default:
				s_nxt.st = toic_pkg::TOIC_ST_IDLE;
		endcase
		// Computer released as soon as the transfer is started
		if (fin)
		begin
			s_nxt.st = toic_pkg::TOIC_ST_ACK; // [RQ26]
			s_nxt.wait_ = 1'b0;
		end
		// Errors come last so they beat a same-cycle clear or completion
		for (int u = 0; u < `TOIC_NUNITS; u++)
		begin
			if (tape_error[u] && s.rd_busy && s.rd_u == 4'(u))
			begin
				s_nxt.rd_fail = 1'b1;
				s_nxt.rd_busy = 1'b0;
				s_nxt.fwd[u] = 1'b0;
				s_nxt.bwd[u] = 1'b0;
				s_nxt.uop[u] = s.uop[u]; // [RQ24]
			end
			if (tape_error[u] && s.wr_busy && s.wr_u == 4'(u))
			begin
				s_nxt.wr_fail = 1'b1;
				s_nxt.wr_busy = 1'b0;
				s_nxt.wrt[u] = 1'b0;
				s_nxt.wvalid = 1'b0;
				s_nxt.uop[u] = s.uop[u];
				ob.clr = 1'b1;
			end
		end
		s_nxt.lamps = lamp_nxt;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.wait_ <= `TOIC_WAIT_RST;
			s.map <= `TOIC_MAP_RST;
		end
		else if (ce)
			s <= s_nxt;
	end

	assign avs_readdata = s.rdata;
	assign avs_waitrequest = s.wait_;
	assign mem_addr = s.mem_addr;
	assign mem_re = s.mem_re;
	assign mem_we = s.mem_we;
	assign mem_wdata = s.mem_wdata;
	assign wr_digit_valid = s.wvalid;
	assign wr_digit = s.wdig;
	assign wr_low_density = s.wr_low;
	assign tape_fwd = s.fwd;
	assign tape_bwd = s.bwd;
	assign tape_write = s.wrt;
	assign tape_rewind = s.rew;
	assign lamps = s.lamps;

	a_wr_ring_stall: assert property (@(posedge clk) disable iff (!nrst) // [RQ2]
		(s.st == toic_pkg::TOIC_ST_CHECK && is_wr && s.hasu && tape_ring[s.pu])
		|=> s.st == toic_pkg::TOIC_ST_CHECK) else $error("write ran past a ring");
	a_wr_go_clear: assert property (@(posedge clk) disable iff (!nrst) // [RQ3]
		(ce && s.st == toic_pkg::TOIC_ST_CHECK && is_wr && s.hasu && !blk_wr)
		|=> s.st == toic_pkg::TOIC_ST_M2O) else $error("clear write did not proceed");
	a_rd_stall: assert property (@(posedge clk) disable iff (!nrst) // [RQ5]
		(s.st == toic_pkg::TOIC_ST_CHECK && is_rd && s.hasu && s.rd_busy)
		|=> s.st == toic_pkg::TOIC_ST_CHECK && s.wait_) else $error("read not stalled");
	a_rw_overlap: assert property (@(posedge clk) disable iff (!nrst) // [RQ6]
		(ce && s.st == toic_pkg::TOIC_ST_CHECK && is_wr && s.hasu && s.rd_busy &&
		!s.wr_busy && !s.wr_fail && !ub[s.pu] && !s.lock[s.pu] && !tape_ring[s.pu])
		|=> s.st == toic_pkg::TOIC_ST_M2O) else $error("write held by other read");
	a_lock_stall: assert property (@(posedge clk) disable iff (!nrst) // [RQ21]
		(s.st == toic_pkg::TOIC_ST_CHECK && (is_rd || is_wr) && s.hasu && s.lock[s.pu])
		|=> s.st == toic_pkg::TOIC_ST_CHECK) else $error("locked unit used");
	a_one_ack: assert property (@(posedge clk) disable iff (!nrst) // [RQ26]
		(ce && !s.wait_) |=> (s.wait_ && s.st == toic_pkg::TOIC_ST_IDLE))
		else $error("answer not one cycle");
	a_wr_from_buf: assert property (@(posedge clk) disable iff (!nrst) // [RQ17]
		$rose(s.wr_busy) |-> ($past(s.pend) && $past(s.pidx) == `TOIC_LAST_WORD))
		else $error("write started before 60 words");
	a_wr_stop: assert property (@(posedge clk) disable iff (!nrst) // [RQ27]
		(ce && s.wr_busy && s.wvalid && wr_digit_ready && s.ww == `TOIC_LAST_WORD &&
		s.wd == `TOIC_LAST_DIGIT) |=> (!s.wr_busy && s.wrt == '0))
		else $error("tape not stopped after last digit");
	a_hole_pause: assert property (@(posedge clk) disable iff (!nrst) // [RQ22]
		(s.rd_busy && tape_hole[s.rd_u]) |=> ($stable(s.rw) && $stable(s.rd)))
		else $error("read advanced in punched region");
endmodule // toic_ctl
`default_nettype wire

// *** bench/toic_tape_model.sv ***
// Far side model: main memory with 1-cycle read latency and the tape units.
// Assumes the controller's registered motion levels and digit handshakes.
`timescale 1ns/1ns
`default_nettype none
module toic_tape_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [9:0] mem_addr,
	input wire logic mem_re,
	input wire logic mem_we,
	input wire logic [71:0] mem_wdata,
	output logic [71:0] mem_rdata,
	input wire logic [9:0] tape_fwd,
	input wire logic [9:0] tape_bwd,
	input wire logic [9:0] tape_write,
	input wire logic [9:0] tape_rewind,
	output logic [9:0] tape_ready,
	output logic [9:0] tape_rew_done,
	output logic rd_digit_valid,
	output logic [5:0] rd_digit,
	output logic wr_digit_ready,
	input wire logic wr_digit_valid,
	input wire logic [5:0] wr_digit,
	output logic [11:0] wr_count,
	output logic [5:0] first_wr
);
	logic [71:0] mem [0:1023];
	logic [9:0] rdn;
	logic tog;
	int rc;
	initial
	begin
		for (int i = 0; i < 1024; i++)
			mem[i] = {6'(i) ^ 6'h15, 66'(i)};
	end
	assign tape_ready = 10'h3ff;
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rc <= 0;
			rdn <= 10'h000;
			tog <= 1'b0;
			wr_count <= 12'h000;
			first_wr <= 6'h00;
			rd_digit_valid <= 1'b0;
			rd_digit <= 6'h00;
			wr_digit_ready <= 1'b0;
			tape_rew_done <= 10'h000;
			mem_rdata <= 72'h0;
		end
		else
		begin
			if (mem_we)
				mem[mem_addr] <= mem_wdata;
			mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
			// Digit stream numbered from the block start; inverted when idle
			if (|(tape_fwd | tape_bwd))
			begin
				rd_digit_valid <= 1'b1;
				// Backward motion meets the block's last digit first
				rd_digit <= (|tape_bwd) ? 6'(10'd719 - rdn) : rdn[5:0];
				rdn <= rdn + 10'h001;
			end
			else
			begin
				rd_digit_valid <= 1'b0;
				rd_digit <= ~rd_digit;
				rdn <= 10'h000;
			end
			// Half-rate ready, a slow unit
			tog <= ~tog;
			wr_digit_ready <= tog;
			if (wr_digit_valid && wr_digit_ready)
			begin
				if (wr_count == 12'h000)
					first_wr <= wr_digit;
				wr_count <= wr_count + 12'h001;
			end
			rc <= (|tape_rewind) ? rc + 1 : 0;
			tape_rew_done <= (rc == 8) ? tape_rewind : 10'h000;
		end
	end
endmodule // toic_tape_model
`default_nettype wire

// *** bench/toic_ctl_tb.sv ***
// Self-checking bench for the tape order and interlock control.
// Assumes toic_tape_model as memory and tape units; Avalon master tasks below.
`timescale 1ns/1ns
`default_nettype none
module toic_ctl_tb;
	logic clk, nrst, ce, avs_read, avs_write, avs_waitrequest, rd_digit_valid;
	logic wr_digit_ready, wr_digit_valid, wr_low_density, mem_re, mem_we;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rv;
	logic [9:0] mem_addr, tape_ready, tape_ring, tape_removed, tape_rew_done, tape_hole;
	logic [9:0] tape_error, tape_fwd, tape_bwd, tape_write, tape_rewind;
	logic [71:0] mem_wdata, mem_rdata;
	logic [5:0] rd_digit, wr_digit, first_wr;
	logic [11:0] wr_count;
	logic [69:0] lamps;
	int fail_count, checks, cyc;
	toic_ctl toic_ctl_i (.clk, .nrst, .ce, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .mem_addr, .mem_re, .mem_we,
		.mem_wdata, .mem_rdata, .tape_ready, .tape_ring, .tape_removed, .tape_rew_done,
		.tape_hole, .tape_error, .rd_digit_valid, .rd_digit, .wr_digit_ready,
		.wr_digit_valid, .wr_digit, .wr_low_density, .tape_fwd, .tape_bwd, .tape_write,
		.tape_rewind, .lamps);
	toic_tape_model toic_tape_model_i (.clk, .nrst, .mem_addr, .mem_re, .mem_we,
		.mem_wdata, .mem_rdata, .tape_fwd, .tape_bwd, .tape_write, .tape_rewind,
		.tape_ready, .tape_rew_done, .rd_digit_valid, .rd_digit, .wr_digit_ready,
		.wr_digit_valid, .wr_digit, .wr_count, .first_wr);
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task chk(input logic [71:0] got, input logic [71:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Held until waitrequest is sampled low; no fixed latency assumed
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	task idle_wait;
		do @(posedge clk); while (|(tape_write | tape_fwd | tape_bwd | tape_rewind));
	endtask
	function automatic logic [71:0] expw(input int w);
		logic [71:0] r;
		r = 72'h0;
		for (int d = 0; d < 12; d++)
			r = {r[65:0], 6'(12 * w + d)};
		return r;
	endfunction
	task t_regs;
		bus(1'b0, 4'h4, 32'h0);
		chk(rv, 32'h0);
		bus(1'b0, 4'h2, 32'h0);
		chk(rv, 32'h0);
	endtask
	task t_ring_write;
		fork
			bus(1'b1, 4'h0, {14'h0, 10'd100, 4'h1, 4'h5});
			begin
				repeat (40) @(posedge clk);
				chk(avs_waitrequest, 1'b1);
				chk(tape_write, 10'h000);
				tape_ring <= 10'h000;
			end
		join
		chk(tape_write, 10'h001);
		chk(wr_low_density, 1'b0);
		chk(lamps[6:0] & 7'h7e, 7'h48);
		idle_wait();
		chk(wr_count, 12'd720);
		chk(first_wr, 6'(100) ^ 6'h15);
	endtask
	task t_read_and_write;
		bus(1'b1, 4'h0, {14'h0, 10'd0, 4'h2, 4'h1});
		chk(lamps[13:7] & 7'h7e, 7'h28);
		bus(1'b1, 4'h0, {14'h0, 10'd200, 4'h3, 4'h7});
		chk(tape_fwd, 10'h002);
		chk(tape_write, 10'h004);
		chk(wr_low_density, 1'b1);
		tape_hole <= 10'h004;
		repeat (4) @(posedge clk);
		rv = {20'h0, wr_count};
		repeat (20) @(posedge clk);
		chk(wr_count, rv);
		tape_hole <= 10'h000;
		idle_wait();
		chk(wr_count, 12'd1440);
		bus(1'b1, 4'h0, {14'h0, 10'd300, 4'h0, 4'h3});
		chk(toic_tape_model_i.mem[300], expw(0));
		chk(toic_tape_model_i.mem[359], expw(59));
		bus(1'b1, 4'h0, {14'h0, 10'd400, 4'h0, 4'h4});
		chk(toic_tape_model_i.mem[400], 72'h0);
	endtask
	task t_rewind;
		bus(1'b1, 4'h0, {24'h0, 4'ha, 4'h6});
		chk(tape_rewind, 10'h200);
		chk(lamps[69:63] & 7'h7e, 7'h02);
		bus(1'b1, 4'h0, {24'h0, 4'h4, 4'h8});
		chk(lamps[27:21] & 7'h7e, 7'h06);
		idle_wait();
		bus(1'b0, 4'h4, 32'h0);
		chk(rv[13:4], 10'h008);
		fork
			bus(1'b1, 4'h0, {14'h0, 10'd500, 4'h4, 4'h4});
			begin
				repeat (30) @(posedge clk);
				chk(avs_waitrequest, 1'b1);
				tape_removed <= 10'h008;
			end
		join
		tape_removed <= 10'h000;
		chk(tape_bwd, 10'h008);
		chk(lamps[27:21] & 7'h7e, 7'h30);
		idle_wait();
		bus(1'b0, 4'h4, 32'h0);
		chk(rv[13:4], 10'h000);
		bus(1'b1, 4'h0, {14'h0, 10'd600, 4'h0, 4'h3});
		chk(toic_tape_model_i.mem[600], expw(0));
		chk(toic_tape_model_i.mem[659], expw(59));
		bus(1'b1, 4'hc, 32'h15a);
		bus(1'b0, 4'hc, 32'h0);
		chk(rv, 32'h15a);
		bus(1'b1, 4'h0, {24'h0, 4'h5, 4'h6});
		chk(tape_rewind, 10'h200);
	endtask
	// Ceiling well above the roughly 4100 cycles the scenarios need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			close_out();
		end
	end
	initial
	begin
		nrst = 1'b0;
		ce = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		tape_ring = 10'h001;
		tape_removed = 10'h000;
		tape_hole = 10'h000;
		tape_error = 10'h000;
		cyc = 0;
		fail_count = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_ring_write();
		t_read_and_write();
		t_rewind();
		close_out();
	end
endmodule // toic_ctl_tb
`default_nettype wire
